// ### rtl/ldc_pkg.sv
/*
 led driver control package: register map, field positions, reset values,
 timing constants and shared types.
 assumes a 10 MHz core clock.
*/
package ldc_pkg;
   // register indices on the bus and on the serial link
   localparam logic [7:0] ADDR_FLASH_A = 8'h00;
   localparam logic [7:0] ADDR_FLASH_B = 8'h01;
   localparam logic [7:0] ADDR_TORCH = 8'h02;
   localparam logic [7:0] ADDR_IND = 8'h03;
   localparam logic [7:0] ADDR_ENCTL = 8'h04;
   localparam logic [7:0] ADDR_BLANK = 8'h05;
   localparam logic [7:0] ADDR_THERM = 8'h06;
   localparam logic [7:0] ADDR_STATUS = 8'h07;
   // reset values
   localparam logic [7:0] RST_CUR = 8'h00;
   localparam logic [7:0] RST_ENCTL = 8'hc0;
   localparam logic [7:0] RST_BLANK = 8'h00;
   localparam logic [7:0] RST_THERM = 8'h40;
   // enable-control fields
   localparam int EN_PIN_IND = 0;
   localparam int EN_PIN_MOVIE = 1;
   localparam int EN_PIN_FLASH = 2;
   localparam int EN_SW_IND = 3;
   localparam int EN_SW_MOVIE = 4;
   localparam int EN_SW_FLASH = 5;
   localparam int EN_SEL_A = 6;
   // blanking-current fields
   localparam int BLANK_POL = 7;
   localparam int BLANK_VAL_W = 7;
   // status fields
   localparam int ST_BLANK = 0;
   localparam int ST_HOT = 1;
   localparam int ST_FLASH = 2;
   localparam int ST_MOVIE = 3;
   localparam int ST_IND = 4;
   localparam int ST_EXPIRED = 5;
   localparam int ST_LOCKOUT = 6;
   // flash safety timer
   localparam int CLK_HZ = 10000000;
   localparam int SAFETY_TIME_MS = 50;
   localparam int SAFETY_CYCLES = SAFETY_TIME_MS * (CLK_HZ / 1000);
   localparam int TMR_W = 24;

   typedef enum logic [2:0] {
      TMR_IDLE = 3'b001,
      TMR_FLASH = 3'b010,
      TMR_DONE = 3'b100
   } ldc_tmr_t;

   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] data;
   } ldc_wr_t;
endpackage

// ### rtl/ldc_sync.sv
/*
 two flip-flop level synchroniser, one chain per bit.
 assumes inputs are levels or toggles that hold for several clocks.
*/
`timescale 1ns/1ns
module ldc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // levels
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic s1_r;
         logic s2_r;
         always_ff @(posedge clk_in or negedge rst_n_in)
         begin
            if (!rst_n_in)
            begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
            end
            else
            begin
               s1_r <= d_in[i];
               s2_r <= s1_r; // [RL13]
            end
         end
         assign q_out[i] = s2_r;
      end
   endgenerate
endmodule

// ### rtl/ldc_link.sv
/*
 serial link end on the serial clock: 16-bit frames, read/write bit,
 7-bit register index, 8 data bits, msb first.
 assumes the serial clock only runs during frames and that the core
 answers a read request by toggle handshake before the next read frame.
*/
`timescale 1ns/1ns
module ldc_link (
   // link clock and reset
   input wire logic scl_clk_in,
   input wire logic rst_n_in,
   // data pin
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // to core
   output ldc_pkg::ldc_wr_t wr_word_out,
   output logic wr_tgl_out,
   output logic [6:0] rd_addr_out,
   output logic rd_tgl_out,
   // from core
   input wire logic [7:0] rd_hold_in,
   input wire logic rd_ack_in
);
   import ldc_pkg::*;

   logic [3:0] bit_cnt_r;
   logic rw_r;
   logic [13:0] sh_r;
   logic ack_s1_r;
   logic ack_s2_r;
   logic ack_seen_r;
   logic [7:0] hold_r;

   always_ff @(posedge scl_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         bit_cnt_r <= 4'h0;
         rw_r <= 1'b0;
         sh_r <= 14'h0000;
         wr_word_out <= '0;
         wr_tgl_out <= 1'b0;
         rd_addr_out <= 7'h00;
         rd_tgl_out <= 1'b0;
      end
      else
      begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
         if (bit_cnt_r == 4'h0)
            rw_r <= sda_in; // [RL2]
         else
            sh_r <= {sh_r[12:0], sda_in}; // [RL2]
         if (bit_cnt_r == 4'hf && !rw_r)
         begin
            wr_word_out <= '{addr: sh_r[13:7], data: {sh_r[6:0], sda_in}};
            wr_tgl_out <= ~wr_tgl_out;
         end
         if (bit_cnt_r == 4'h7 && rw_r)
         begin
            rd_addr_out <= {sh_r[5:0], sda_in};
            rd_tgl_out <= ~rd_tgl_out;
         end
      end
   end

   // read data handshake into the link domain
   always_ff @(posedge scl_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
         ack_seen_r <= 1'b0;
         hold_r <= 8'h00;
      end
      else
      begin
         ack_s1_r <= rd_ack_in;
         ack_s2_r <= ack_s1_r;
         if (ack_s2_r != ack_seen_r)
         begin
            ack_seen_r <= ack_s2_r;
            hold_r <= rd_hold_in;
         end
      end
   end

   // data out changes on the falling edge
   always_ff @(negedge scl_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sda_out <= 1'b0;
         sda_oe_out <= 1'b0;
      end
      else if (bit_cnt_r[3] && rw_r)
      begin
         sda_oe_out <= 1'b1; // [RL3]
         sda_out <= hold_r[3'(4'hf - bit_cnt_r)]; // [RL3]
      end
      else
      begin
         sda_oe_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end

   property p_tx_window;
      @(posedge scl_clk_in) disable iff (!rst_n_in)
      rw_r && bit_cnt_r >= 4'h8 |-> sda_oe_out && sda_out == hold_r[3'(4'hf - bit_cnt_r)];
   endproperty
   a_tx_window: assert property (p_tx_window) else $error("read bit not driven from falling edge"); // [RL3]

   property p_rx_word;
      @(posedge scl_clk_in) disable iff (!rst_n_in)
      bit_cnt_r == 4'hf && !rw_r |=> wr_word_out.data == {$past(sh_r[6:0]), $past(sda_in)};
   endproperty
   a_rx_word: assert property (p_rx_word) else $error("write data not taken on rising edges"); // [RL2]
endmodule

// ### rtl/ldc_top.sv
/*
 led driver control inputs: register file on a plain port and on the
 serial link, pin enable steering, blanking current, flash safety timer,
 thermistor trip compare and supply lockout.
 assumes a 10 MHz core clock, an unrelated serial clock, and a thermistor
 reading that is produced on the core clock.
*/
`timescale 1ns/1ns
// How it works
// [RL1] supply lockout resets every register and turns the boost converter off
// [RL2] serial data is sampled on each rising serial clock edge
// [RL3] returned serial data changes on the falling serial clock edge
// [RL4] led enable pin switches regulators, selection held in enable-control register
// [RL5] while blanking, active currents are replaced by the blanking value
// [RL6] blanking never touches safety timer or stored current registers
// [RL7] blanking polarity comes from a register bit, active high after reset
// [RL8] flash uses own flash register, movie uses shared torch register
// [RL9] indicator current comes from the indicator-current register
// [RL10] thermistor reading compared with programmed trip threshold for overtemperature
// [RL11] flash beats movie; on timer expiry regulator falls back to movie
// [RL12] three bits decide whether the pin drives indicator, movie, flash
// [RL13] led enable and blanking pins pass two flip-flops before use
module ldc_top #(
   parameter int SAFETY_CYC = ldc_pkg::SAFETY_CYCLES
) (
   // clocks and reset
   input wire logic REF_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic SCL_CLK_IN,
   // register port
   input wire logic [7:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [7:0] RDATA_OUT,
   // serial data pin
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_OUT,
   // control pins
   input wire logic LED_ENABLE_IN,
   input wire logic TX_BLANK_IN,
   input wire logic SUPPLY_LOCKOUT_IN,
   // thermistor reading
   input wire logic [7:0] THERM_LEVEL_IN,
   // regulator settings
   output logic [7:0] FLASH_A_CUR_OUT,
   output logic [7:0] FLASH_B_CUR_OUT,
   output logic [7:0] INDICATOR_CURRENT_REG_OUT,
   output logic BOOST_EN_OUT,
   output logic OVERTEMP_OUT
);
   import ldc_pkg::*;

   logic [2:0] pins_s;
   logic led_s;
   logic blank_s;
   logic lockout_s;
   ldc_wr_t link_word;
   logic link_wr_tgl;
   logic [6:0] link_rd_addr;
   logic link_rd_tgl;
   logic [1:0] tgl_s;
   logic wr_seen_r;
   logic rd_seen_r;
   logic link_pend_r;
   logic [7:0] rd_hold_r;
   logic rd_ack_r;
   logic [7:0] flash_a_r;
   logic [7:0] flash_b_r;
   logic [7:0] torch_r;
   logic [7:0] ind_r;
   logic [7:0] enctl_r;
   logic [7:0] blank_r;
   logic [7:0] therm_r;
   logic [7:0] status;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic blank_act;
   logic [7:0] blank_val;
   logic flash_any;
   logic ind_on;
   logic [1:0] flash_on;
   logic [1:0] movie_on;
   logic [1:0] flash_act;
   logic [7:0] flash_cur [2];
   logic [7:0] cur_r [2];
   ldc_tmr_t tmr_st_r;
   logic [TMR_W-1:0] tmr_cnt_r;

   ldc_sync #(.W(3)) u_pin_sync (
      .clk_in(REF_CLK_IN),
      .rst_n_in(RESETN_IN),
      .d_in({SUPPLY_LOCKOUT_IN, TX_BLANK_IN, LED_ENABLE_IN}),
      .q_out(pins_s)
   );
   assign led_s = pins_s[0]; // [RL13]
   assign blank_s = pins_s[1]; // [RL13]
   assign lockout_s = pins_s[2];

   ldc_link u_link (
      .scl_clk_in(SCL_CLK_IN),
      .rst_n_in(RESETN_IN),
      .sda_in(SDA_IN),
      .sda_out(SDA_OUT),
      .sda_oe_out(SDA_OE_OUT),
      .wr_word_out(link_word),
      .wr_tgl_out(link_wr_tgl),
      .rd_addr_out(link_rd_addr),
      .rd_tgl_out(link_rd_tgl),
      .rd_hold_in(rd_hold_r),
      .rd_ack_in(rd_ack_r)
   );

   ldc_sync #(.W(2)) u_tgl_sync (
      .clk_in(REF_CLK_IN),
      .rst_n_in(RESETN_IN),
      .d_in({link_rd_tgl, link_wr_tgl}),
      .q_out(tgl_s)
   );

   function automatic logic [7:0] rd_mux(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == ADDR_FLASH_A)
         v = flash_a_r;
      else if (a == ADDR_FLASH_B)
         v = flash_b_r;
      else if (a == ADDR_TORCH)
         v = torch_r;
      else if (a == ADDR_IND)
         v = ind_r;
      else if (a == ADDR_ENCTL)
         v = enctl_r;
      else if (a == ADDR_BLANK)
         v = blank_r;
      else if (a == ADDR_THERM)
         v = therm_r;
      else if (a == ADDR_STATUS)
         v = status;
      return v;
   endfunction

   // link requests: a link write waits behind a port write until WR_IN is low
   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         wr_seen_r <= 1'b0;
         rd_seen_r <= 1'b0;
         link_pend_r <= 1'b0;
         rd_hold_r <= 8'h00;
         rd_ack_r <= 1'b0;
      end
      else
      begin
         wr_seen_r <= tgl_s[0];
         rd_seen_r <= tgl_s[1];
         if (tgl_s[0] != wr_seen_r)
            link_pend_r <= 1'b1;
         else if (!WR_IN)
            link_pend_r <= 1'b0;
         if (tgl_s[1] != rd_seen_r)
         begin
            rd_hold_r <= rd_mux({1'b0, link_rd_addr});
            rd_ack_r <= ~rd_ack_r;
         end
      end
   end

   always_comb
   begin
      wr_en = WR_IN | link_pend_r;
      wr_addr = WR_IN ? ADDR_IN : {1'b0, link_word.addr};
      wr_data = WR_IN ? WDATA_IN : link_word.data;
   end

   // register file
   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         flash_a_r <= RST_CUR;
         flash_b_r <= RST_CUR;
         torch_r <= RST_CUR;
         ind_r <= RST_CUR;
         enctl_r <= RST_ENCTL;
         blank_r <= RST_BLANK;
         therm_r <= RST_THERM;
      end
      else if (lockout_s)
      begin
         flash_a_r <= RST_CUR; // [RL1]
         flash_b_r <= RST_CUR;
         torch_r <= RST_CUR;
         ind_r <= RST_CUR;
         enctl_r <= RST_ENCTL;
         blank_r <= RST_BLANK; // [RL7]
         therm_r <= RST_THERM;
      end
      else if (wr_en)
      begin
         if (wr_addr == ADDR_FLASH_A)
            flash_a_r <= wr_data;
         else if (wr_addr == ADDR_FLASH_B)
            flash_b_r <= wr_data;
         else if (wr_addr == ADDR_TORCH)
            torch_r <= wr_data;
         else if (wr_addr == ADDR_IND)
            ind_r <= wr_data;
         else if (wr_addr == ADDR_ENCTL)
            enctl_r <= wr_data;
         else if (wr_addr == ADDR_BLANK)
            blank_r <= wr_data;
         else if (wr_addr == ADDR_THERM)
            therm_r <= wr_data;
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         RDATA_OUT <= 8'h00;
      else if (RD_IN)
         RDATA_OUT <= rd_mux(ADDR_IN);
      else
         RDATA_OUT <= 8'h00;
   end

   // pin steering and mode selection
   assign blank_act = blank_s ^ blank_r[BLANK_POL]; // [RL7]
   assign blank_val = {1'b0, blank_r[BLANK_VAL_W-1:0]};
   assign ind_on = (led_s & enctl_r[EN_PIN_IND]) | enctl_r[EN_SW_IND]; // [RL12]
   assign flash_cur[0] = flash_a_r;
   assign flash_cur[1] = flash_b_r;
   assign flash_any = |flash_on;

   genvar i;
   generate
      for (i = 0; i < 2; i++)
      begin : g_reg
         logic [7:0] cur_nxt;
         logic pin_sel;
         assign pin_sel = led_s & enctl_r[EN_SEL_A + i]; // [RL4]
         assign flash_on[i] = (pin_sel & enctl_r[EN_PIN_FLASH]) | enctl_r[EN_SW_FLASH]; // [RL12]
         assign movie_on[i] = (pin_sel & enctl_r[EN_PIN_MOVIE]) | enctl_r[EN_SW_MOVIE]; // [RL12]
         assign flash_act[i] = flash_on[i] & (tmr_st_r != TMR_DONE) & ~OVERTEMP_OUT; // [RL11]
         always_comb
         begin
            cur_nxt = 8'h00;
            if (flash_act[i])
               cur_nxt = blank_act ? blank_val : flash_cur[i]; // [RL8] [RL5]
            else if (movie_on[i])
               cur_nxt = blank_act ? blank_val : torch_r; // [RL8] [RL11] [RL5]
            if (lockout_s)
               cur_nxt = 8'h00;
         end
         always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
         begin
            if (!RESETN_IN)
               cur_r[i] <= 8'h00;
            else
               cur_r[i] <= cur_nxt;
         end
      end
   endgenerate
   assign FLASH_A_CUR_OUT = cur_r[0];
   assign FLASH_B_CUR_OUT = cur_r[1];

   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         INDICATOR_CURRENT_REG_OUT <= 8'h00;
      else if (lockout_s || !ind_on)
         INDICATOR_CURRENT_REG_OUT <= 8'h00;
      else
         INDICATOR_CURRENT_REG_OUT <= blank_act ? blank_val : ind_r; // [RL9] [RL5]
   end

   // flash safety timer; blanking is not an input here [RL6]
   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         tmr_st_r <= TMR_IDLE;
         tmr_cnt_r <= '0;
      end
      else if (lockout_s)
      begin
         tmr_st_r <= TMR_IDLE;
         tmr_cnt_r <= '0;
      end
      else
      begin
         case (tmr_st_r)
            TMR_IDLE:
            begin
               tmr_cnt_r <= '0;
               if (flash_any)
                  tmr_st_r <= TMR_FLASH;
            end
            TMR_FLASH:
            begin
               if (!flash_any)
                  tmr_st_r <= TMR_IDLE;
               else if (tmr_cnt_r == TMR_W'(SAFETY_CYC - 1))
                  tmr_st_r <= TMR_DONE; // [RL11]
               else
                  tmr_cnt_r <= tmr_cnt_r + 1'b1;
            end
            TMR_DONE:
            begin
               if (!flash_any)
                  tmr_st_r <= TMR_IDLE;
            end
            default:
               tmr_st_r <= TMR_IDLE;
         endcase
      end
   end

   // thermistor trip and converter enable
   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         OVERTEMP_OUT <= 1'b0;
         BOOST_EN_OUT <= 1'b0;
      end
      else
      begin
         OVERTEMP_OUT <= THERM_LEVEL_IN < therm_r; // [RL10]
         BOOST_EN_OUT <= ~lockout_s & ((|flash_on) | (|movie_on) | ind_on); // [RL1]
      end
   end

   assign status = {1'b0, lockout_s, tmr_st_r == TMR_DONE, ind_on, |movie_on, |flash_act,
                    OVERTEMP_OUT, blank_act};

   property p_lockout_regs;
      @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      lockout_s |=> enctl_r == RST_ENCTL && flash_a_r == RST_CUR && blank_r == RST_BLANK;
   endproperty
   a_lockout_regs: assert property (p_lockout_regs) else $error("lockout left registers set"); // [RL1]

   property p_lockout_boost;
      @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      lockout_s |=> !BOOST_EN_OUT && FLASH_A_CUR_OUT == 8'h00 && INDICATOR_CURRENT_REG_OUT == 8'h00;
   endproperty
   a_lockout_boost: assert property (p_lockout_boost) else $error("converter on under lockout"); // [RL1]

   property p_blank_cur;
      @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      blank_act && !lockout_s && (flash_act[0] || movie_on[0]) |=> FLASH_A_CUR_OUT == $past(blank_val);
   endproperty
   a_blank_cur: assert property (p_blank_cur) else $error("blanking value not applied"); // [RL5]

   property p_blank_keeps;
      @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      $changed(blank_s) && !wr_en && !lockout_s && tmr_st_r == TMR_FLASH && flash_any
      |=> tmr_st_r != TMR_IDLE && $stable(flash_a_r) && $stable(torch_r);
   endproperty
   a_blank_keeps: assert property (p_blank_keeps) else $error("blanking disturbed timer or registers"); // [RL6]

   property p_polarity;
      @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      blank_r[BLANK_POL] && !blank_s && !lockout_s && ind_on |=> INDICATOR_CURRENT_REG_OUT == $past(blank_val);
   endproperty
   a_polarity: assert property (p_polarity) else $error("inverted blanking not honoured"); // [RL7]

   property p_flash_src;
      @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      flash_act[1] && !blank_act && !lockout_s |=> FLASH_B_CUR_OUT == $past(flash_b_r);
   endproperty
   a_flash_src: assert property (p_flash_src) else $error("flash current not from own register"); // [RL8]

   property p_fallback;
      @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      tmr_st_r == TMR_DONE && movie_on[0] && !blank_act && !lockout_s |=> FLASH_A_CUR_OUT == $past(torch_r);
   endproperty
   a_fallback: assert property (p_fallback) else $error("no fall back to torch current"); // [RL11]

   property p_ind_src;
      @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      enctl_r[EN_PIN_IND] && led_s && !blank_act && !lockout_s |=> INDICATOR_CURRENT_REG_OUT == $past(ind_r);
   endproperty
   a_ind_src: assert property (p_ind_src) else $error("indicator not driven from its register"); // [RL9]

   property p_pin_off;
      @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      !led_s && enctl_r[5:3] == 3'b000 |=> FLASH_A_CUR_OUT == 8'h00 && INDICATOR_CURRENT_REG_OUT == 8'h00;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("regulator on without enable"); // [RL4]

   property p_overtemp;
      @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      THERM_LEVEL_IN < therm_r && !lockout_s ##1 flash_on[0] && !movie_on[0] |=> FLASH_A_CUR_OUT == 8'h00;
   endproperty
   a_overtemp: assert property (p_overtemp) else $error("flash continued over temperature"); // [RL10]
endmodule

// ### bench/ldc_host.sv
/*
 host model on the serial link: 16-bit frames, clock only inside frames.
 assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ns
module ldc_host (
   // link pins
   output logic scl_out,
   output logic sda_drv_out,
   output logic sda_en_out,
   input wire logic sda_in
);
   logic [15:0] rx_r;
   initial
   begin
      scl_out = 1'b0;
      sda_drv_out = 1'b1;
      sda_en_out = 1'b0;
   end
   // read flag, index, data, msb first; released for data bits of a read
   task automatic frame(input logic rd, input logic [6:0] idx, input logic [7:0] dat, output logic [7:0] got);
      logic [15:0] w;
      w = {rd, idx, dat};
      for (int i = 15; i >= 0; i--)
      begin
         sda_en_out = !(rd && i < 8);
         sda_drv_out = w[i];
         #15 scl_out = 1'b1;
         rx_r[i] = sda_in;
         #15 scl_out = 1'b0;
      end
      sda_en_out = 1'b0;
      got = rx_r[7:0];
      #1000;
   endtask
endmodule

// ### bench/ldc_top_tb.sv
/*
 self-checking bench for the led driver control inputs.
 assumes the design's notes on latency: 3 cycles from pin to current.
*/
`timescale 1ns/1ns
module ldc_top_tb;
   import ldc_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic led_enable_in = 1'b0;
   logic blank = 1'b0;
   logic lockout = 1'b0;
   logic rd_d = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] therm = 8'hff;
   logic [7:0] rdata, fa, fb, ic, v, got;
   logic scl, hdrv, hen, sda_o, sda_oe, boost, hot;
   logic [7:0] exp_q[$];
   int seed = 32'h1e8b4009;
   int mismatches = 0;
   int num_checks = 0;
   wire logic sda = sda_oe ? sda_o : (hen ? hdrv : 1'b1);

   always #50 ref_clk = ~ref_clk;

   ldc_top #(.SAFETY_CYC(20)) dut (.REF_CLK_IN(ref_clk), .RESETN_IN(resetn), .SCL_CLK_IN(scl),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
      .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .LED_ENABLE_IN(led_enable_in),
      .TX_BLANK_IN(blank), .SUPPLY_LOCKOUT_IN(lockout), .THERM_LEVEL_IN(therm),
      .FLASH_A_CUR_OUT(fa), .FLASH_B_CUR_OUT(fb), .INDICATOR_CURRENT_REG_OUT(ic), .BOOST_EN_OUT(boost),
      .OVERTEMP_OUT(hot));
   ldc_host host (.scl_out(scl), .sda_drv_out(hdrv), .sda_en_out(hen), .sda_in(sda));

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      num_checks++;
      if (seen !== want)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   // expectation noted here, compared by the read monitor
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      exp_q.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   always @(posedge ref_clk) rd_d <= rd;
   always @(negedge ref_clk)
      if (rd_d === 1'b1)
         check(rdata, exp_q.pop_front());

   initial
   begin
      #2000000;
      mismatches++;
      conclude();
   end

   initial
   begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 4; i++)
         rd_reg(8'(i), RST_CUR);
      rd_reg(ADDR_ENCTL, RST_ENCTL);
      rd_reg(ADDR_BLANK, RST_BLANK);
      rd_reg(ADDR_THERM, RST_THERM);
      wr_reg(ADDR_STATUS, 8'hff);
      rd_reg(ADDR_STATUS, 8'h00);
      rd_reg(8'h3f, 8'h00);
      $display("test reset values done");
      v = $random(seed);
      host.frame(1'b0, ADDR_TORCH[6:0], v, got);
      rd_reg(ADDR_TORCH, v);
      host.frame(1'b1, ADDR_TORCH[6:0], 8'h00, got);
      check(got, 8'h00);
      host.frame(1'b1, ADDR_IND[6:0], 8'h00, got);
      check(got, v);
      $display("test serial link done");
      for (int i = 0; i < 7; i++)
      begin
         v = $random(seed);
         wr_reg(8'(i), v);
         rd_reg(8'(i), v);
      end
      $display("test register access done");
      wr_reg(ADDR_FLASH_A, 8'h9a);
      wr_reg(ADDR_FLASH_B, 8'h5c);
      wr_reg(ADDR_TORCH, 8'h21);
      wr_reg(ADDR_IND, 8'h0d);
      wr_reg(ADDR_BLANK, 8'h05);
      wr_reg(ADDR_ENCTL, 8'hca);
      @(posedge ref_clk);
      led_enable_in <= 1'b1;
      settle(1);
      check(fa, 8'h00);
      settle(3);
      check(fa, 8'h21);
      check(fb, 8'h21);
      check({7'h0, boost}, 8'h01);
      @(posedge ref_clk);
      blank <= 1'b1;
      settle(4);
      check(fa, 8'h05);
      rd_reg(ADDR_TORCH, 8'h21);
      blank <= 1'b0;
      wr_reg(ADDR_BLANK, 8'h85);
      settle(4);
      check(fb, 8'h05);
      check(ic, 8'h05);
      wr_reg(ADDR_BLANK, 8'h05);
      wr_reg(ADDR_ENCTL, 8'h42);
      settle(4);
      check(fa, 8'h21);
      check(fb, 8'h00);
      @(posedge ref_clk);
      led_enable_in <= 1'b0;
      settle(4);
      check(fa, 8'h00);
      $display("test pin steering and blanking done");
      wr_reg(ADDR_ENCTL, 8'hc7);
      @(posedge ref_clk);
      led_enable_in <= 1'b1;
      settle(4);
      check(fa, 8'h9a);
      check(fb, 8'h5c);
      check(ic, 8'h0d);
      @(posedge ref_clk);
      blank <= 1'b1;
      settle(3);
      check(fa, 8'h05);
      check(ic, 8'h05);
      @(posedge ref_clk);
      blank <= 1'b0;
      settle(3);
      check(fa, 8'h9a);
      settle(16);
      check(fa, 8'h21);
      check(fb, 8'h21);
      @(posedge ref_clk);
      led_enable_in <= 1'b0;
      settle(4);
      check(fb, 8'h00);
      check(ic, 8'h00);
      wr_reg(ADDR_ENCTL, 8'h08);
      settle(3);
      check(ic, 8'h0d);
      $display("test flash timer and indicator done");
      v = 8'h20 + 8'($random(seed) & 8'h7f);
      wr_reg(ADDR_THERM, v);
      for (int i = 0; i < 3; i++)
      begin
         @(posedge ref_clk);
         therm <= (i == 0) ? v : (i == 1) ? v - 8'h01 : 8'($random(seed));
         settle(2);
         check({7'h0, hot}, {7'h0, therm < v});
      end
      @(posedge ref_clk);
      therm <= 8'hff;
      $display("test thermistor compare done");
      wr_reg(ADDR_TORCH, 8'h44);
      lockout <= 1'b1;
      settle(4);
      check(ic, 8'h00);
      check({7'h0, boost}, 8'h00);
      wr_reg(ADDR_FLASH_A, 8'h33);
      lockout <= 1'b0;
      settle(4);
      rd_reg(ADDR_TORCH, RST_CUR);
      rd_reg(ADDR_FLASH_A, RST_CUR);
      rd_reg(ADDR_ENCTL, RST_ENCTL);
      settle(2);
      $display("test supply lockout done");
      conclude();
   end
endmodule
